// [verilog/erb_pkg.sv]
// constants, carriers and state layout for the error report bank register block
package erb_pkg;

  // bus geometry: byte address = 4 * register index, upper half at a fixed page
  localparam int unsigned AXI_AW = 16;
  localparam int unsigned HI_BIT = 14;
  localparam int unsigned TOP_BIT = 15;

  // register indices of the banks and the interrupt registers, one 64-bit bank register per bank index
  localparam logic [11:0] IDX_BANK_BASE = 12'h400;
  localparam logic [11:0] IDX_BANK_STRIDE = 12'h004;
  localparam logic [11:0] IDX_REG_COUNT = 12'h00a;
  localparam logic [11:0] IDX_B0_CTL = 12'h400;
  localparam logic [11:0] IDX_B0_STS = 12'h401;
  localparam logic [11:0] IDX_B0_ADR = 12'h402;
  localparam logic [11:0] IDX_B0_MSC = 12'h403;
  localparam logic [11:0] IDX_B1_CTL = 12'h404;
  localparam logic [11:0] IDX_B1_STS = 12'h405;
  localparam logic [11:0] IDX_B1_ADR = 12'h406;
  localparam logic [11:0] IDX_B1_MSC = 12'h407;
  localparam logic [11:0] IDX_B2_CTL = 12'h408;
  localparam logic [11:0] IDX_B2_STS = 12'h409;
  localparam logic [11:0] IDX_IRQ_STS = 12'h410;
  localparam logic [11:0] IDX_IRQ_MSK = 12'h411;

  // register selector inside a bank
  localparam logic [1:0] SEL_CTL = 2'h0;
  localparam logic [1:0] SEL_STS = 2'h1;
  localparam logic [1:0] SEL_ADR = 2'h2;
  localparam logic [1:0] SEL_MSC = 2'h3;

  // status register fields
  localparam int unsigned STS_VAL_BIT = 63;
  localparam int unsigned STS_INFO_VALID_BIT = 59;
  localparam int unsigned STS_ADDR_VALID_BIT = 58;

  // interrupt status bits: one per bank capture, one for an access fault on an absent register
  localparam int unsigned IRQ_FAULT_BIT = 3;
  localparam int unsigned IRQ_W = 4;

  // values after reset
  localparam logic [63:0] RST_REG64 = 64'h0;
  localparam logic [IRQ_W-1:0] RST_IRQ = 4'h0;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    K_NONE = 2'h0,
    K_BANK = 2'h1,
    K_ISTS = 2'h2,
    K_IMSK = 2'h3
  } erb_kind_t;

  // one error report from the checking logic of a bank
  typedef struct packed {
    logic vld;
    logic has_addr;
    logic has_misc;
    logic [63:0] addr;
    logic [63:0] misc;
  } erb_evt_t;

  // decoded register address
  typedef struct packed {
    erb_kind_t kind;
    logic hi;
    logic [1:0] bank;
    logic [1:0] sel;
    logic fault;
  } erb_dec_t;

  // whole state of the block
  typedef struct packed {
    logic [2:0][63:0] ctl;
    logic [2:0][63:0] sts;
    logic [1:0][63:0] adr;
    logic [1:0][63:0] msc;
    logic [IRQ_W-1:0] ist;
    logic [IRQ_W-1:0] msk;
    logic irq;
    logic aw_have;
    logic [AXI_AW-1:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } erb_state_t;

endpackage

// [verilog/erb_regs.sv]
// register bank of the first three error report banks behind an AXI4-Lite slave
//
// How it works
// - bank 0 address register reads as zero while its address valid flag is clear.
// - bank 0 extra info register reads as zero while its extra info valid flag is clear.
// - bank 1 extra info register reads as zero while its extra info valid flag is clear.
// - any read or write of a bank 0 or 1 address or extra info register that is not built faults; bank 2 ones get a decode error.
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module erb_regs
  import erb_pkg::*;
#(
  parameter logic [1:0] ADDR_IMPL = 2'h3,
  parameter logic [1:0] MISC_IMPL = 2'h3
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // axi4-lite write address and data
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // error reports from the checking logic, one per bank
  input wire erb_evt_t [2:0] err_evt,
  // bank control words for the checking logic
  output logic [2:0][63:0] bank_ctl,
  // interrupt
  output logic irq
);

  erb_state_t s_q;
  erb_state_t s_d;
  erb_dec_t wdec;
  erb_dec_t rdec;
  logic wr_go;
  logic ar_hs;

  // map a byte address onto a register; bank 2 address and extra info are unmapped
  function automatic erb_dec_t decode(input logic [AXI_AW-1:0] a);
    erb_dec_t d;
    logic [11:0] rel;
    d = '0;
    rel = a[13:2] - IDX_BANK_BASE;
    d.kind = K_NONE;
    d.hi = a[HI_BIT];
    d.bank = rel[3:2];
    d.sel = rel[1:0];
    if (!a[TOP_BIT]) begin
      if (a[13:2] >= IDX_BANK_BASE && rel < IDX_REG_COUNT) begin
        d.kind = K_BANK;
      end else if (a[13:2] == IDX_IRQ_STS && !d.hi) begin
        d.kind = K_ISTS;
      end else if (a[13:2] == IDX_IRQ_MSK && !d.hi) begin
        d.kind = K_IMSK;
      end
    end
    if (d.kind == K_BANK) begin
      if (d.sel == SEL_ADR) begin
        d.fault = !ADDR_IMPL[d.bank[0]];
      end else if (d.sel == SEL_MSC) begin
        d.fault = !MISC_IMPL[d.bank[0]];
      end
    end
    return d;
  endfunction

  // byte-lane merge of one bus word into one half of a 64-bit register
  function automatic logic [63:0] merge(input logic [63:0] old, input logic hi,
                                        input logic [31:0] data, input logic [3:0] strb);
    logic [63:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        if (hi) begin
          r[32 + 8 * i +: 8] = data[8 * i +: 8];
        end else begin
          r[8 * i +: 8] = data[8 * i +: 8];
        end
      end
    end
    return r;
  endfunction

  // decoded addresses of the pending write and of the offered read
  always_comb begin
    wdec = decode(s_q.awaddr);
    rdec = decode(s_axi_araddr);
    wr_go = s_q.aw_have && s_q.w_have && !s_q.bvalid;
    ar_hs = s_axi_arvalid && s_q.arready;
  end

  // next state: bus handshakes, software access, then hardware capture so that it wins
  always_comb begin
    logic [63:0] rv;
    logic [1:0] b;
    rv = '0;
    b = '0;
    s_d = s_q;
    // write address and data are taken in either order
    if (s_axi_awvalid && s_q.awready) begin
      s_d.aw_have = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.w_have = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    // perform the write once both halves are held
    if (wr_go) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      b = wdec.bank;
      unique case (wdec.kind)
        K_BANK: begin
          if (wdec.fault) begin
            s_d.bresp = RESP_SLVERR;
            s_d.ist[IRQ_FAULT_BIT] = 1'b1;
          end else if (wdec.sel == SEL_CTL) begin
            s_d.ctl[b] = merge(s_q.ctl[b], wdec.hi, s_q.wdata, s_q.wstrb);
          end else if (wdec.sel == SEL_STS) begin
            s_d.sts[b] = merge(s_q.sts[b], wdec.hi, s_q.wdata, s_q.wstrb);
          end
        end
        K_ISTS: s_d.ist = s_q.ist & ~(s_q.wdata[IRQ_W-1:0] & {IRQ_W{s_q.wstrb[0]}});
        K_IMSK: begin
          if (s_q.wstrb[0]) begin
            s_d.msk = s_q.wdata[IRQ_W-1:0];
          end
        end
        K_NONE: s_d.bresp = RESP_DECERR;
      endcase
    end
    // read answer one cycle after the address is taken
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (ar_hs) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      b = rdec.bank;
      unique case (rdec.kind)
        K_BANK: begin
          unique case (rdec.sel)
            SEL_CTL: rv = s_q.ctl[b];
            SEL_STS: rv = s_q.sts[b];
            SEL_ADR: begin
              if (s_q.sts[b][STS_ADDR_VALID_BIT]) begin
                rv = s_q.adr[b[0]];
              end
            end
            SEL_MSC: begin
              if (s_q.sts[b][STS_INFO_VALID_BIT]) begin
                rv = s_q.msc[b[0]];
              end
            end
          endcase
          if (rdec.fault) begin
            rv = '0;
            s_d.rresp = RESP_SLVERR;
            s_d.ist[IRQ_FAULT_BIT] = 1'b1;
          end
        end
        K_ISTS: rv = {{(64 - IRQ_W){1'b0}}, s_q.ist};
        K_IMSK: rv = {{(64 - IRQ_W){1'b0}}, s_q.msk};
        K_NONE: s_d.rresp = RESP_DECERR;
      endcase
      s_d.rdata = rdec.hi ? rv[63:32] : rv[31:0];
    end
    // hardware error capture: sets status flags and the qualified registers
    for (int i = 0; i < 3; i++) begin
      if (err_evt[i].vld) begin
        s_d.sts[i][STS_VAL_BIT] = 1'b1;
        s_d.ist[i] = 1'b1;
        if (i < 2) begin
          if (err_evt[i].has_addr && ADDR_IMPL[i]) begin
            s_d.adr[i] = err_evt[i].addr;
            s_d.sts[i][STS_ADDR_VALID_BIT] = 1'b1;
          end
          if (err_evt[i].has_misc && MISC_IMPL[i]) begin
            s_d.msc[i] = err_evt[i].misc;
            s_d.sts[i][STS_INFO_VALID_BIT] = 1'b1;
          end
        end
      end
    end
    // ready flags and interrupt from the next state so outputs come from flops
    s_d.awready = !s_d.aw_have && !s_d.bvalid;
    s_d.wready = !s_d.w_have && !s_d.bvalid;
    s_d.arready = !s_d.rvalid;
    s_d.irq = |(s_d.ist & s_d.msk);
  end

  // state register
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.ctl <= {3{RST_REG64}};
      s_q.sts <= {3{RST_REG64}};
      s_q.adr <= {2{RST_REG64}};
      s_q.msc <= {2{RST_REG64}};
      s_q.ist <= RST_IRQ;
      s_q.msk <= RST_IRQ;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs
  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign bank_ctl = s_q.ctl;
  assign irq = s_q.irq;

  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  // a read of a given index in the low half
  sequence s_rd_lo(logic [11:0] idx);
    ar_hs && s_axi_araddr[13:2] == idx && !s_axi_araddr[HI_BIT] && !s_axi_araddr[TOP_BIT];
  endsequence

  // answer that carries no address or info: zero data or a fault
  sequence s_empty_answer;
    s_axi_rvalid && (s_axi_rdata == 32'h0 || s_axi_rresp == RESP_SLVERR);
  endsequence

  property p_b0_addr_empty;
    s_rd_lo(IDX_B0_ADR) and !s_q.sts[0][STS_ADDR_VALID_BIT] |=> s_empty_answer;
  endproperty
  a_b0_addr_empty: assert property (p_b0_addr_empty)
    else $error("bank 0 address read without valid flag returned data");

  property p_b0_misc_empty;
    s_rd_lo(IDX_B0_MSC) and !s_q.sts[0][STS_INFO_VALID_BIT] |=> s_empty_answer;
  endproperty
  a_b0_misc_empty: assert property (p_b0_misc_empty)
    else $error("bank 0 extra info read without valid flag returned data");

  property p_b1_addr_empty;
    s_rd_lo(IDX_B1_ADR) and !s_q.sts[1][STS_ADDR_VALID_BIT] |=> s_empty_answer;
  endproperty
  a_b1_addr_empty: assert property (p_b1_addr_empty)
    else $error("bank 1 address read without valid flag returned data");

  property p_b1_misc_empty;
    s_rd_lo(IDX_B1_MSC) and !s_q.sts[1][STS_INFO_VALID_BIT] |=> s_empty_answer;
  endproperty
  a_b1_misc_empty: assert property (p_b1_misc_empty)
    else $error("bank 1 extra info read without valid flag returned data");

  property p_wr_fault;
    wr_go && wdec.kind == K_BANK && wdec.fault
      |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR && s_q.ist[IRQ_FAULT_BIT];
  endproperty
  a_wr_fault: assert property (p_wr_fault)
    else $error("write to an absent register did not fault");

  property p_rd_fault;
    ar_hs && rdec.kind == K_BANK && rdec.fault
      |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_q.ist[IRQ_FAULT_BIT];
  endproperty
  a_rd_fault: assert property (p_rd_fault)
    else $error("read of an absent register did not fault");

  property p_b2_ctl_place;
    s_rd_lo(IDX_B2_CTL)
      |=> s_axi_rvalid && s_axi_rresp == RESP_OKAY && s_axi_rdata == $past(s_q.ctl[2][31:0]);
  endproperty
  a_b2_ctl_place: assert property (p_b2_ctl_place)
    else $error("bank 2 control not found at its index");

  property p_b1_sts_place;
    s_rd_lo(IDX_B1_STS)
      |=> s_axi_rvalid && s_axi_rdata == $past(s_q.sts[1][31:0]);
  endproperty
  a_b1_sts_place: assert property (p_b1_sts_place)
    else $error("bank 1 status not found at its index");

  // a read of a given index in the high half
  sequence s_rd_hi(logic [11:0] idx);
    ar_hs && s_axi_araddr[13:2] == idx && s_axi_araddr[HI_BIT] && !s_axi_araddr[TOP_BIT];
  endsequence

  property p_b0_addr_hi_empty;
    s_rd_hi(IDX_B0_ADR) and !s_q.sts[0][STS_ADDR_VALID_BIT] |=> s_empty_answer;
  endproperty
  a_b0_addr_hi_empty: assert property (p_b0_addr_hi_empty)
    else $error("bank 0 address upper read without valid flag returned data");

  // with the flag set the captured address comes through, not a constant zero
  property p_b0_addr_shown;
    s_rd_lo(IDX_B0_ADR) and s_q.sts[0][STS_ADDR_VALID_BIT] && ADDR_IMPL[0]
      |=> s_axi_rvalid && s_axi_rresp == RESP_OKAY && s_axi_rdata == $past(s_q.adr[0][31:0]);
  endproperty
  a_b0_addr_shown: assert property (p_b0_addr_shown)
    else $error("bank 0 address with valid flag did not return its word");

  property p_b1_misc_shown;
    s_rd_hi(IDX_B1_MSC) and s_q.sts[1][STS_INFO_VALID_BIT] && MISC_IMPL[1]
      |=> s_axi_rvalid && s_axi_rresp == RESP_OKAY && s_axi_rdata == $past(s_q.msc[1][63:32]);
  endproperty
  a_b1_misc_shown: assert property (p_b1_misc_shown)
    else $error("bank 1 extra info with valid flag did not return its word");

  // a capture with extra info raises the flag and loads the register together
  property p_b0_misc_capture;
    err_evt[0].vld && err_evt[0].has_misc && MISC_IMPL[0]
      |=> s_q.sts[0][STS_INFO_VALID_BIT] && s_q.msc[0] == $past(err_evt[0].misc);
  endproperty
  a_b0_misc_capture: assert property (p_b0_misc_capture)
    else $error("bank 0 extra info capture did not raise its valid flag");

  // the bank 2 address slot lies outside the map
  property p_b2_gap;
    s_rd_lo(IDX_B2_STS + 12'h001) |=> s_axi_rvalid && s_axi_rresp == RESP_DECERR;
  endproperty
  a_b2_gap: assert property (p_b2_gap)
    else $error("bank 2 address slot answered as a register");

endmodule

`default_nettype wire

// [test/error_report_bank_regs_tb.sv]
// self-checking bench for the error report bank register block
`timescale 1ns/1ps
`default_nettype none

module error_report_bank_regs_tb
  import erb_pkg::*;
();
  // clock, reset and bus pins
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [AXI_AW-1:0] s_axi_awaddr = '0;
  logic [AXI_AW-1:0] s_axi_araddr = '0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  erb_evt_t [2:0] err_evt = '0;
  logic [2:0][63:0] bank_ctl;
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [31:0] d;
  logic [1:0] r;

  // bank 1 address register left out so that the fault path is reachable
  erb_regs #(.ADDR_IMPL(2'h1), .MISC_IMPL(2'h3)) i_erb_regs (
    .ref_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .err_evt, .bank_ctl, .irq
  );

  // 200 MHz clock
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  // watchdog against a hung handshake
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      end_of_test();
    end
  end

  // byte address of a register word, hi selects the upper page
  function automatic logic [15:0] ba(input logic [11:0] idx, input logic hi);
    return {1'b0, hi, idx, 2'b00};
  endfunction

  task automatic chk(input string n, input logic [63:0] got, input logic [63:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("wrong value %s expected %h seen %h", n, exp, got);
    end
  endtask

  // one write: address and data offered together, each dropped when taken
  task automatic wr(input logic [15:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bready && s_axi_bvalid) begin
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask

  // one read, data and response taken at the rvalid edge
  task automatic rd(input logic [15:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rready && s_axi_rvalid) begin
        v = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask

  // one-cycle error report pulse on bank i
  task automatic ev(input int i, input logic ha, input logic hm, input logic [63:0] a,
                    input logic [63:0] m);
    @(posedge ref_clk);
    err_evt[i] <= '{vld: 1'b1, has_addr: ha, has_misc: hm, addr: a, misc: m};
    @(posedge ref_clk);
    err_evt[i].vld <= 1'b0;
  endtask

  // reset values, then bank layout by write and read back
  task automatic t_map();
    logic [11:0] ix [6];
    ix = '{IDX_B0_CTL, IDX_B0_STS, IDX_B1_CTL, IDX_B1_STS, IDX_B2_CTL, IDX_B2_STS};
    foreach (ix[k]) begin
      rd(ba(ix[k], 1'b0), d, r);
      chk("reset word", d, 32'h0);
      wr(ba(ix[k], 1'b0), {8'ha5, 12'h0, ix[k]}, r);
      chk("write resp", r, RESP_OKAY);
    end
    foreach (ix[k]) begin
      rd(ba(ix[k], 1'b0), d, r);
      chk("read back", d, {8'ha5, 12'h0, ix[k]});
    end
    chk("bank2 ctl out", bank_ctl[2], {8'ha5, 12'h0, IDX_B2_CTL});
    rd(ba(IDX_B2_STS + 12'h001, 1'b0), d, r);
    chk("bank2 addr resp", r, RESP_DECERR);
    wr(ba(IDX_B2_STS + 12'h002, 1'b0), 32'h1, r);
    chk("bank2 info wr resp", r, RESP_DECERR);
    $display("test map done");
  endtask

  // validity flags qualify the address and extra info registers
  task automatic t_flags();
    ev(0, 1'b1, 1'b1, 64'h1234_5678_9abc_def0, 64'h0fed_cba9_8765_4321);
    rd(ba(IDX_B0_STS, 1'b1), d, r);
    chk("sts0 hi", d, 32'h8c00_0000);
    rd(ba(IDX_B0_ADR, 1'b0), d, r);
    chk("adr0 lo", d, 32'h9abc_def0);
    rd(ba(IDX_B0_ADR, 1'b1), d, r);
    chk("adr0 hi", d, 32'h1234_5678);
    rd(ba(IDX_B0_MSC, 1'b0), d, r);
    chk("msc0 lo", d, 32'h8765_4321);
    wr(ba(IDX_B0_STS, 1'b1), 32'h0, r);
    rd(ba(IDX_B0_ADR, 1'b1), d, r);
    chk("adr0 cleared", d, 32'h0);
    rd(ba(IDX_B0_ADR, 1'b0), d, r);
    chk("adr0 lo cleared", d, 32'h0);
    rd(ba(IDX_B0_MSC, 1'b0), d, r);
    chk("msc0 cleared", d, 32'h0);
    ev(1, 1'b1, 1'b1, 64'h1, 64'h5555_0000_aaaa_0001);
    rd(ba(IDX_B1_STS, 1'b1), d, r);
    chk("sts1 hi", d, 32'h8800_0000);
    rd(ba(IDX_B1_MSC, 1'b1), d, r);
    chk("msc1 hi", d, 32'h5555_0000);
    wr(ba(IDX_B1_STS, 1'b1), 32'h8000_0000, r);
    rd(ba(IDX_B1_MSC, 1'b0), d, r);
    chk("msc1 cleared", d, 32'h0);
    $display("test flags done");
  endtask

  // absent register faults on read and write
  task automatic t_fault();
    rd(ba(IDX_B1_ADR, 1'b0), d, r);
    chk("absent rd resp", r, RESP_SLVERR);
    chk("absent rd data", d, 32'h0);
    wr(ba(IDX_B1_ADR, 1'b1), 32'hffff_ffff, r);
    chk("absent wr resp", r, RESP_SLVERR);
    rd(ba(IDX_IRQ_STS, 1'b0), d, r);
    chk("irq sts", d, 32'hb);
    $display("test fault done");
  endtask

  // interrupt masked, unmasked and cleared
  task automatic t_irq();
    wr(ba(IDX_IRQ_STS, 1'b0), 32'hf, r);
    wr(ba(IDX_IRQ_MSK, 1'b0), 32'h0, r);
    ev(2, 1'b0, 1'b0, 64'h0, 64'h0);
    repeat (2) @(posedge ref_clk);
    chk("irq masked", irq, 1'b0);
    rd(ba(IDX_IRQ_STS, 1'b0), d, r);
    chk("irq sts bank2", d, 32'h4);
    wr(ba(IDX_IRQ_MSK, 1'b0), 32'h4, r);
    repeat (2) @(posedge ref_clk);
    chk("irq on", irq, 1'b1);
    wr(ba(IDX_IRQ_STS, 1'b0), 32'h4, r);
    repeat (2) @(posedge ref_clk);
    chk("irq off", irq, 1'b0);
    $display("test irq done");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    t_map();
    t_flags();
    t_fault();
    t_irq();
    end_of_test();
  end
endmodule

`default_nettype wire
